// file: rtl/pimfs_pkg.sv
package pimfs_pkg;

   localparam int SLOTS   = 8;
   localparam int SLOT_W  = 3;
   localparam int CODE_W  = 3;
   localparam int COUNT_W = 12;
   localparam int MASK_W  = 8;
   localparam int FRAME_W = 5;
   localparam int UFC_W   = 14;
   localparam int INT_W   = 2;
   localparam int ADDR_W  = 6;

   // frame number field inside descriptor_word_three
   localparam int FRAME_LSB = 3;
   localparam int FRAME_MSB = 7;
   // bus frame bits inside the microframe counter
   localparam int UFC_FRAME_LSB = 3;
   localparam int UFC_FRAME_MSB = 7;
   // slot_result_code fields of descriptor_word_five start above the mask
   localparam int CODE_LSB = 8;

   localparam int CODE_ERR      = 0;
   localparam int CODE_BABBLE   = 1;
   localparam int CODE_UNDERRUN = 2;

   localparam int INT_DONE = 0;
   localparam int INT_ERR  = 1;

   localparam logic [ADDR_W-1:0] OFS_WORD_THREE = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_WORD_FIVE  = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK   = 6'h0c;
   localparam logic [ADDR_W-1:0] OFS_COUNT_BASE = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_COUNT_LAST = 6'h2c;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [MASK_W-1:0]  MASK_RST  = 8'h00;
   localparam logic [FRAME_W-1:0] FRAME_RST = 5'h00;
   localparam logic [CODE_W-1:0]  CODE_RST  = 3'h0;
   localparam logic [COUNT_W-1:0] COUNT_RST = 12'h000;
   localparam logic [INT_W-1:0]   INT_RST   = 2'h0;

   typedef struct packed {
      logic               transErr;
      logic               babble;
      logic               underrun;
      logic               isIn;
      logic [COUNT_W-1:0] byteCount;
   } pimfs_result_type;

   typedef enum logic [0:0] {
      SCHED_IDLE = 1'b0,
      SCHED_WAIT = 1'b1
   } pimfs_sched_type;

   typedef enum logic [1:0] {
      RD_IDLE   = 2'b00,
      RD_FETCH  = 2'b01,
      RD_LOAD   = 2'b10,
      RD_ANSWER = 2'b11
   } pimfs_read_type;

endpackage

// file: rtl/pimfs_count_ram.sv
`timescale 1ns/10ps
`default_nettype none
module pimfs_count_ram (
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   input  wire logic                         wrEn,
   input  wire logic [pimfs_pkg::SLOT_W-1:0] wrAddr,
   input  wire logic [pimfs_pkg::COUNT_W-1:0] wrData,
   input  wire logic [pimfs_pkg::SLOT_W-1:0] rdAddr,
   output logic      [pimfs_pkg::COUNT_W-1:0] rdData
);

   logic [pimfs_pkg::COUNT_W-1:0] mem [0:pimfs_pkg::SLOTS-1];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < pimfs_pkg::SLOTS; i++) begin
            mem[i] <= pimfs_pkg::COUNT_RST;
         end
         rdData <= pimfs_pkg::COUNT_RST;
      end else begin
         if (wrEn) begin
            mem[wrAddr] <= wrData;
         end
         rdData <= mem[rdAddr];
      end
   end

endmodule
`default_nettype wire

// file: rtl/pimfs_slot_pick.sv
`timescale 1ns/10ps
`default_nettype none
module pimfs_slot_pick (
   input  wire logic [pimfs_pkg::MASK_W-1:0]  activeMask,
   input  wire logic [pimfs_pkg::FRAME_W-1:0] descFrame,
   input  wire logic [pimfs_pkg::UFC_W-1:0]   microframeCount,
   input  wire pimfs_pkg::pimfs_result_type   result,
   output logic                               armed,
   output logic      [pimfs_pkg::SLOT_W-1:0]  slotIdx,
   output logic      [pimfs_pkg::CODE_W-1:0]  slotCode
);

   always_comb begin
      // [R9] slot from counter
      slotIdx = microframeCount[pimfs_pkg::SLOT_W-1:0];
      // [R5] frame match gate
      armed = (descFrame == microframeCount[pimfs_pkg::UFC_FRAME_MSB:pimfs_pkg::UFC_FRAME_LSB])
              && activeMask[slotIdx];
      // [R3] direction qualifies code
      slotCode = '0;
      slotCode[pimfs_pkg::CODE_ERR]      = result.transErr;
      slotCode[pimfs_pkg::CODE_BABBLE]   = result.babble & result.isIn;
      slotCode[pimfs_pkg::CODE_UNDERRUN] = result.underrun & ~result.isIn;
   end

endmodule
`default_nettype wire

// file: rtl/pimfs_sched.sv
// Operation
// [R1] eight 3-bit result codes, slot 7 at bits 31:29 down to slot 0 at 10:8, hardware-written
// [R2] after each slot transaction completes, write that slot's result code
// [R3] code bit 0 error, bit 1 babble for IN, bit 2 underrun for OUT
// [R4] 8-bit active mask; software arms bits, hardware clears each after processing
// [R5] consult mask only when descriptor frame bits 7:3 equal bus frame number
// [R6] in a matching frame, issue token for a slot only when its bit is set
// [R7] every armed slot gets its own transaction independently; the code ignores a start pulse while a transaction is pending
// [R8] record 12-bit received byte count per slot when armed and frame matched
// [R9] slot index is the low three bits of the microframe counter
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pimfs_sched (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic [pimfs_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [pimfs_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic                          sofPulse,
   input  wire logic [pimfs_pkg::UFC_W-1:0]   microframeCount,
   input  wire logic                          txnDone,
   input  wire pimfs_pkg::pimfs_result_type   txnResult,
   output logic                               tokenIssue,
   output logic [pimfs_pkg::SLOT_W-1:0]       tokenSlot,
   output logic                               irq
);

   ////////////////////////////////////////////////////////////////////////////
   logic                            awTakenQ, awTakenD, wTakenQ, wTakenD;
   logic [pimfs_pkg::ADDR_W-1:0]    awAddrQ, awAddrD, arAddrQ, arAddrD;
   logic [7:0]                      wByteQ, wByteD;
   logic                            wLaneQ, wLaneD;
   logic                            awReadyQ, awReadyD, wReadyQ, wReadyD;
   logic                            bValidQ, bValidD, arReadyQ, arReadyD;
   logic                            rValidQ, rValidD;
   logic [1:0]                      bRespQ, bRespD, rRespQ, rRespD;
   logic [31:0]                     rDataQ, rDataD;
   pimfs_pkg::pimfs_read_type       rdStateQ, rdStateD;
   logic                            doWrite;

   logic [pimfs_pkg::MASK_W-1:0]    maskQ, maskD;
   logic [pimfs_pkg::FRAME_W-1:0]   frameQ, frameD;
   logic [pimfs_pkg::CODE_W-1:0]    codeQ [pimfs_pkg::SLOTS], codeD [pimfs_pkg::SLOTS];
   logic [pimfs_pkg::INT_W-1:0]     intStatusQ, intStatusD, intMaskQ, intMaskD;
   logic                            irqQ, irqD;
   pimfs_pkg::pimfs_sched_type      schedQ, schedD;
   logic                            issueQ, issueD;
   logic [pimfs_pkg::SLOT_W-1:0]    slotQ, slotD;

   logic                            armed, finish, ramWrEn;
   logic [pimfs_pkg::SLOT_W-1:0]    curSlot;
   logic [pimfs_pkg::CODE_W-1:0]    newCode;
   logic [pimfs_pkg::COUNT_W-1:0]   ramData;
   logic [pimfs_pkg::ADDR_W-1:0]    countOff;
   logic [pimfs_pkg::CODE_W*pimfs_pkg::SLOTS-1:0] codeFlat;
   logic [31:0]                     wordThree, wordFive;

   ////////////////////////////////////////////////////////////////////////////
   pimfs_slot_pick u_pick (
      .activeMask      (maskQ),
      .descFrame       (frameQ),
      .microframeCount (microframeCount),
      .result          (txnResult),
      .armed           (armed),
      .slotIdx         (curSlot),
      .slotCode        (newCode)
   );

   assign countOff = arAddrQ - pimfs_pkg::OFS_COUNT_BASE;
   assign finish   = (schedQ == pimfs_pkg::SCHED_WAIT) && txnDone;
   // [R8] only IN byte counts stored
   assign ramWrEn  = finish && txnResult.isIn;

   pimfs_count_ram u_ram (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wrEn    (ramWrEn),
      .wrAddr  (slotQ),
      .wrData  (txnResult.byteCount),
      .rdAddr  (countOff[pimfs_pkg::SLOT_W+1:2]),
      .rdData  (ramData)
   );

   // [R1] codes packed slot 7 high
   for (genvar g = 0; g < pimfs_pkg::SLOTS; g++) begin : g_pack
      assign codeFlat[g*pimfs_pkg::CODE_W +: pimfs_pkg::CODE_W] = codeQ[g];
   end
   assign wordThree = {24'h000000, frameQ, 3'h0};
   assign wordFive  = {codeFlat, maskQ};

   ////////////////////////////////////////////////////////////////////////////
   // bus slave; only byte lane 0 holds writable bits
   always_comb begin
      awTakenD = awTakenQ;
      awAddrD  = awAddrQ;
      wTakenD  = wTakenQ;
      wByteD   = wByteQ;
      wLaneD   = wLaneQ;
      bValidD  = bValidQ;
      bRespD   = bRespQ;
      doWrite  = 1'b0;
      if (s_axi_awvalid && awReadyQ) begin
         awTakenD = 1'b1;
         awAddrD  = s_axi_awaddr;
      end
      if (s_axi_wvalid && wReadyQ) begin
         wTakenD = 1'b1;
         wByteD  = s_axi_wdata[7:0];
         wLaneD  = s_axi_wstrb[0];
      end
      if (bValidQ && s_axi_bready) begin
         bValidD = 1'b0;
      end
      if (awTakenQ && wTakenQ && !bValidQ) begin
         doWrite  = wLaneQ;
         awTakenD = 1'b0;
         wTakenD  = 1'b0;
         bValidD  = 1'b1;
         bRespD   = (awAddrQ == pimfs_pkg::OFS_WORD_THREE || awAddrQ == pimfs_pkg::OFS_WORD_FIVE
                     || awAddrQ == pimfs_pkg::OFS_INT_STATUS || awAddrQ == pimfs_pkg::OFS_INT_MASK
                     || (awAddrQ >= pimfs_pkg::OFS_COUNT_BASE && awAddrQ <= pimfs_pkg::OFS_COUNT_LAST
                         && awAddrQ[1:0] == 2'h0)) ? pimfs_pkg::RESP_OKAY : pimfs_pkg::RESP_SLVERR;
      end
      awReadyD = !awTakenD && !bValidD;
      wReadyD  = !wTakenD && !bValidD;
   end

   always_comb begin
      rdStateD = rdStateQ;
      arAddrD  = arAddrQ;
      arReadyD = arReadyQ;
      rValidD  = rValidQ;
      rDataD   = rDataQ;
      rRespD   = rRespQ;
      case (rdStateQ)
         pimfs_pkg::RD_IDLE: begin
            if (s_axi_arvalid && arReadyQ) begin
               arAddrD  = s_axi_araddr;
               arReadyD = 1'b0;
               rdStateD = pimfs_pkg::RD_FETCH;
            end
         end
         pimfs_pkg::RD_FETCH: begin
            rdStateD = pimfs_pkg::RD_LOAD;
         end
         pimfs_pkg::RD_LOAD: begin
            rRespD  = pimfs_pkg::RESP_OKAY;
            rValidD = 1'b1;
            rdStateD = pimfs_pkg::RD_ANSWER;
            if (arAddrQ == pimfs_pkg::OFS_WORD_THREE) begin
               rDataD = wordThree;
            end else if (arAddrQ == pimfs_pkg::OFS_WORD_FIVE) begin
               rDataD = wordFive;
            end else if (arAddrQ == pimfs_pkg::OFS_INT_STATUS) begin
               rDataD = {30'h00000000, intStatusQ};
            end else if (arAddrQ == pimfs_pkg::OFS_INT_MASK) begin
               rDataD = {30'h00000000, intMaskQ};
            end else if (arAddrQ >= pimfs_pkg::OFS_COUNT_BASE && arAddrQ <= pimfs_pkg::OFS_COUNT_LAST
                         && arAddrQ[1:0] == 2'h0) begin
               rDataD = {20'h00000, ramData};
            end else begin
               rDataD = 32'h00000000;
               rRespD = pimfs_pkg::RESP_SLVERR;
            end
         end
         pimfs_pkg::RD_ANSWER: begin
            if (s_axi_rready) begin
               rValidD  = 1'b0;
               arReadyD = 1'b1;
               rdStateD = pimfs_pkg::RD_IDLE;
            end
         end
         default: begin
            rdStateD = pimfs_pkg::RD_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // scheduler and descriptor state
   always_comb begin
      schedD     = schedQ;
      issueD     = 1'b0;
      slotD      = slotQ;
      maskD      = maskQ;
      frameD     = frameQ;
      codeD      = codeQ;
      intStatusD = intStatusQ;
      intMaskD   = intMaskQ;
      case (schedQ)
         pimfs_pkg::SCHED_IDLE: begin
            // [R6] token only for armed slot
            if (sofPulse && armed) begin
               issueD = 1'b1;
               slotD  = curSlot;
               schedD = pimfs_pkg::SCHED_WAIT;
            end
         end
         pimfs_pkg::SCHED_WAIT: begin
            if (txnDone) begin
               // [R2] result code written
               codeD[slotQ] = newCode;
               // [R4] hardware clears armed bit
               maskD[slotQ] = 1'b0;
               schedD = pimfs_pkg::SCHED_IDLE;
            end
         end
         default: begin
            schedD = pimfs_pkg::SCHED_IDLE;
         end
      endcase
      // a clear is done first so a software arm in the same cycle wins
      if (doWrite) begin
         case (awAddrQ)
            pimfs_pkg::OFS_WORD_THREE: frameD = wByteQ[pimfs_pkg::FRAME_MSB:pimfs_pkg::FRAME_LSB];
            pimfs_pkg::OFS_WORD_FIVE:  maskD = wByteQ | (maskD & 8'h00);
            pimfs_pkg::OFS_INT_STATUS: intStatusD = intStatusD & ~wByteQ[pimfs_pkg::INT_W-1:0];
            pimfs_pkg::OFS_INT_MASK:   intMaskD = wByteQ[pimfs_pkg::INT_W-1:0];
            default: begin
            end
         endcase
      end
      if (finish) begin
         intStatusD[pimfs_pkg::INT_DONE] = 1'b1;
         intStatusD[pimfs_pkg::INT_ERR]  = intStatusD[pimfs_pkg::INT_ERR] | (|newCode);
      end
      irqD = |(intStatusQ & intMaskQ);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         awTakenQ   <= 1'b0;
         awAddrQ    <= '0;
         wTakenQ    <= 1'b0;
         wByteQ     <= 8'h00;
         wLaneQ     <= 1'b0;
         awReadyQ   <= 1'b0;
         wReadyQ    <= 1'b0;
         bValidQ    <= 1'b0;
         bRespQ     <= pimfs_pkg::RESP_OKAY;
         arReadyQ   <= 1'b1;
         arAddrQ    <= '0;
         rValidQ    <= 1'b0;
         rRespQ     <= pimfs_pkg::RESP_OKAY;
         rDataQ     <= 32'h00000000;
         rdStateQ   <= pimfs_pkg::RD_IDLE;
         schedQ     <= pimfs_pkg::SCHED_IDLE;
         issueQ     <= 1'b0;
         slotQ      <= '0;
         maskQ      <= pimfs_pkg::MASK_RST;
         frameQ     <= pimfs_pkg::FRAME_RST;
         for (int i = 0; i < pimfs_pkg::SLOTS; i++) begin
            codeQ[i] <= pimfs_pkg::CODE_RST;
         end
         intStatusQ <= pimfs_pkg::INT_RST;
         intMaskQ   <= pimfs_pkg::INT_RST;
         irqQ       <= 1'b0;
      end else begin
         awTakenQ   <= awTakenD;
         awAddrQ    <= awAddrD;
         wTakenQ    <= wTakenD;
         wByteQ     <= wByteD;
         wLaneQ     <= wLaneD;
         awReadyQ   <= awReadyD;
         wReadyQ    <= wReadyD;
         bValidQ    <= bValidD;
         bRespQ     <= bRespD;
         arReadyQ   <= arReadyD;
         arAddrQ    <= arAddrD;
         rValidQ    <= rValidD;
         rRespQ     <= rRespD;
         rDataQ     <= rDataD;
         rdStateQ   <= rdStateD;
         schedQ     <= schedD;
         issueQ     <= issueD;
         slotQ      <= slotD;
         maskQ      <= maskD;
         frameQ     <= frameD;
         codeQ      <= codeD;
         intStatusQ <= intStatusD;
         intMaskQ   <= intMaskD;
         irqQ       <= irqD;
      end
   end

   assign s_axi_awready = awReadyQ;
   assign s_axi_wready  = wReadyQ;
   assign s_axi_bvalid  = bValidQ;
   assign s_axi_bresp   = bRespQ;
   assign s_axi_arready = arReadyQ;
   assign s_axi_rvalid  = rValidQ;
   assign s_axi_rdata   = rDataQ;
   assign s_axi_rresp   = rRespQ;
   assign tokenIssue    = issueQ;
   assign tokenSlot     = slotQ;
   assign irq           = irqQ;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_finish;
      schedQ == pimfs_pkg::SCHED_WAIT && txnDone;
   endsequence

   property p_code_pack;
      @(posedge ref_clk) disable iff (rst)
      s_finish |=> wordFive[pimfs_pkg::CODE_LSB + slotQ*pimfs_pkg::CODE_W +: pimfs_pkg::CODE_W] == $past(newCode);
   endproperty
   a_code_pack: assert property (p_code_pack) else $error("result code not packed at slot field"); // [R1]

   property p_code_write;
      @(posedge ref_clk) disable iff (rst)
      s_finish ##1 (schedQ == pimfs_pkg::SCHED_IDLE) |-> codeQ[slotQ] == $past(newCode);
   endproperty
   a_code_write: assert property (p_code_write) else $error("result code not written"); // [R2]

   property p_dir_code;
      @(posedge ref_clk) disable iff (rst)
      (schedQ == pimfs_pkg::SCHED_WAIT) && txnDone && !txnResult.isIn
         |=> !codeQ[slotQ][pimfs_pkg::CODE_BABBLE];
   endproperty
   a_dir_code: assert property (p_dir_code) else $error("babble flagged on an out token"); // [R3]

   property p_mask_clear;
      @(posedge ref_clk) disable iff (rst)
      (schedQ == pimfs_pkg::SCHED_WAIT) && txnDone && !doWrite |=> !maskQ[slotQ];
   endproperty
   a_mask_clear: assert property (p_mask_clear) else $error("armed bit not cleared"); // [R4]

   property p_issue_cause;
      @(posedge ref_clk) disable iff (rst)
      $rose(tokenIssue) |-> $past(sofPulse) && $past(armed)
         && $past(frameQ) == $past(microframeCount[pimfs_pkg::UFC_FRAME_MSB:pimfs_pkg::UFC_FRAME_LSB]);
   endproperty
   a_issue_cause: assert property (p_issue_cause) else $error("token without frame match"); // [R5]

   property p_issue_armed;
      @(posedge ref_clk) disable iff (rst)
      tokenIssue |-> $past(maskQ[microframeCount[pimfs_pkg::SLOT_W-1:0]]);
   endproperty
   a_issue_armed: assert property (p_issue_armed) else $error("token for unarmed slot"); // [R6]

   property p_issue_each;
      @(posedge ref_clk) disable iff (rst)
      sofPulse && armed && schedQ == pimfs_pkg::SCHED_IDLE |=> tokenIssue ##1 !tokenIssue;
   endproperty
   a_issue_each: assert property (p_issue_each) else $error("armed slot got no single token"); // [R7]

   property p_count_gate;
      @(posedge ref_clk) disable iff (rst)
      ramWrEn |-> schedQ == pimfs_pkg::SCHED_WAIT && txnResult.isIn && maskQ[slotQ];
   endproperty
   a_count_gate: assert property (p_count_gate) else $error("byte count stored without armed slot"); // [R8]

   property p_slot_sel;
      @(posedge ref_clk) disable iff (rst)
      sofPulse && armed && schedQ == pimfs_pkg::SCHED_IDLE
         |=> tokenSlot == $past(microframeCount[pimfs_pkg::SLOT_W-1:0]);
   endproperty
   a_slot_sel: assert property (p_slot_sel) else $error("token slot differs from counter"); // [R9]

endmodule
`default_nettype wire

// file: tb/pimfs_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module pimfs_peer_model (
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   input  wire logic                         tokenIssue,
   input  wire logic [pimfs_pkg::SLOT_W-1:0] tokenSlot,
   input  wire logic [3:0]                   replyDelay,
   output logic                              txnDone,
   output pimfs_pkg::pimfs_result_type       txnResult
);
   logic                         busyQ;
   logic [3:0]                   waitQ;
   logic [pimfs_pkg::SLOT_W-1:0] slotQ;

   ////////////////////////////////////////////////////////////////////////////
   // result depends on slot; idle result lines toggle so nothing stale is read
   always @(posedge ref_clk) begin
      txnDone <= 1'b0;
      txnResult <= ~txnResult;
      if (rst) begin
         busyQ <= 1'b0;
         waitQ <= 4'h0;
         slotQ <= 3'h0;
         txnResult <= '0;
      end else if (tokenIssue) begin
         busyQ <= 1'b1;
         waitQ <= replyDelay;
         slotQ <= tokenSlot;
      end else if (busyQ && waitQ > 4'h1) begin
         waitQ <= waitQ - 4'h1;
      end else if (busyQ) begin
         busyQ <= 1'b0;
         txnDone <= 1'b1;
         txnResult <= {slotQ[0], 1'b1, 1'b1, ~slotQ[1], 12'h100 + {9'h000, slotQ}};
      end
   end
endmodule
`default_nettype wire

// file: tb/periodic_int_microframe_sched_bench.sv
`timescale 1ns/10ps
`default_nettype none
module periodic_int_microframe_sched_bench;
   logic                        ref_clk = 1'b0;
   logic                        rst = 1'b1;
   logic [5:0]                  awAddr = 6'h00;
   logic                        awValid = 1'b0;
   logic                        awReady;
   logic [31:0]                 wData = 32'h0;
   logic                        wValid = 1'b0;
   logic                        wReady;
   logic [1:0]                  bResp;
   logic                        bValid;
   logic                        bReady = 1'b0;
   logic [5:0]                  arAddr = 6'h00;
   logic                        arValid = 1'b0;
   logic                        arReady;
   logic [31:0]                 rData;
   logic [1:0]                  rResp;
   logic                        rValid;
   logic                        rReady = 1'b0;
   logic                        sofPulse = 1'b0;
   logic [13:0]                 mfCount = 14'h0;
   logic                        txnDone;
   pimfs_pkg::pimfs_result_type txnResult;
   logic                        tokenIssue;
   logic [2:0]                  tokenSlot;
   logic                        irq;
   logic [3:0]                  replyDelay = 4'h1;
   int                          errors = 0;
   int                          comparisons = 0;

   always #25 ref_clk = ~ref_clk;

   pimfs_sched u_dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .sofPulse(sofPulse),
      .microframeCount(mfCount), .txnDone(txnDone), .txnResult(txnResult), .tokenIssue(tokenIssue),
      .tokenSlot(tokenSlot), .irq(irq));

   pimfs_peer_model u_peer (.ref_clk(ref_clk), .rst(rst), .tokenIssue(tokenIssue), .tokenSlot(tokenSlot),
      .replyDelay(replyDelay), .txnDone(txnDone), .txnResult(txnResult));

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // handshakes sampled at negedge, where the next rising edge will see them
   task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] expResp);
      logic       aw;
      logic       w;
      logic       b;
      logic [1:0] r;
      @(posedge ref_clk);
      awAddr <= a;
      awValid <= 1'b1;
      wData <= d;
      wValid <= 1'b1;
      bReady <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         aw = awValid && awReady;
         w = wValid && wReady;
         b = bValid;
         r = bResp;
         @(posedge ref_clk);
         if (aw) awValid <= 1'b0;
         if (w) wValid <= 1'b0;
         if (b) begin
            bReady <= 1'b0;
            check(r, expResp);
            return;
         end
      end
      errors++;
      final_report();
   endtask

   task automatic axi_rd(input logic [5:0] a, input logic [31:0] expData, input logic [1:0] expResp);
      logic        ar;
      logic        rv;
      logic [31:0] d;
      logic [1:0]  r;
      @(posedge ref_clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         ar = arValid && arReady;
         rv = rValid;
         d = rData;
         r = rResp;
         @(posedge ref_clk);
         if (ar) arValid <= 1'b0;
         if (rv) begin
            rReady <= 1'b0;
            check(d, expData);
            check(r, expResp);
            return;
         end
      end
      errors++;
      final_report();
   endtask

   // one microframe: start pulse, then count tokens over a fixed window
   task automatic uframe(input logic [4:0] fr, input logic [2:0] s, input logic exp);
      int         tok;
      logic [2:0] got;
      tok = 0;
      got = 3'h0;
      @(posedge ref_clk);
      mfCount <= {6'h00, fr, s};
      sofPulse <= 1'b1;
      @(posedge ref_clk);
      sofPulse <= 1'b0;
      for (int n = 0; n < 16; n++) begin
         @(negedge ref_clk);
         if (tokenIssue === 1'b1) begin
            tok++;
            got = tokenSlot;
         end
      end
      check(tok, {31'h0, exp});
      if (exp) check({29'h0, got}, {29'h0, s});
   endtask

   function automatic logic [31:0] five_exp(input logic [7:0] done, input logic [7:0] msk);
      logic [31:0] r;
      logic [2:0]  sv;
      r = {24'h000000, msk};
      for (int s = 0; s < 8; s++) begin
         sv = 3'(s);
         if (done[s]) r[8+3*s +: 3] = {sv[1], ~sv[1], sv[0]};
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      axi_rd(pimfs_pkg::OFS_WORD_THREE, 32'h0, pimfs_pkg::RESP_OKAY);
      axi_rd(pimfs_pkg::OFS_WORD_FIVE, 32'h0, pimfs_pkg::RESP_OKAY);
      axi_rd(pimfs_pkg::OFS_INT_STATUS, 32'h0, pimfs_pkg::RESP_OKAY);
      axi_rd(pimfs_pkg::OFS_INT_MASK, 32'h0, pimfs_pkg::RESP_OKAY);
      axi_rd(6'h30, 32'h0, pimfs_pkg::RESP_SLVERR);
      axi_wr(6'h02, 32'hffffffff, pimfs_pkg::RESP_SLVERR);
      axi_wr(pimfs_pkg::OFS_WORD_THREE, 32'h28, pimfs_pkg::RESP_OKAY);
      axi_rd(pimfs_pkg::OFS_WORD_THREE, 32'h28, pimfs_pkg::RESP_OKAY);
      axi_wr(pimfs_pkg::OFS_WORD_FIVE, 32'h11, pimfs_pkg::RESP_OKAY);
      for (int s = 0; s < 8; s++) uframe(5'h05, 3'(s), s == 0 || s == 4);
      axi_rd(pimfs_pkg::OFS_WORD_FIVE, five_exp(8'h11, 8'h00), pimfs_pkg::RESP_OKAY);
      axi_rd(pimfs_pkg::OFS_INT_STATUS, 32'h3, pimfs_pkg::RESP_OKAY);
      check({31'h0, irq}, 32'h0);
      axi_wr(pimfs_pkg::OFS_INT_MASK, 32'h1, pimfs_pkg::RESP_OKAY);
      repeat (3) @(negedge ref_clk);
      check({31'h0, irq}, 32'h1);
      axi_wr(pimfs_pkg::OFS_INT_STATUS, 32'h3, pimfs_pkg::RESP_OKAY);
      repeat (3) @(negedge ref_clk);
      check({31'h0, irq}, 32'h0);
      axi_rd(pimfs_pkg::OFS_INT_STATUS, 32'h0, pimfs_pkg::RESP_OKAY);
      axi_wr(pimfs_pkg::OFS_WORD_FIVE, 32'hff, pimfs_pkg::RESP_OKAY);
      replyDelay <= 4'h5;
      uframe(5'h06, 3'h0, 1'b0);
      axi_rd(pimfs_pkg::OFS_WORD_FIVE, five_exp(8'h11, 8'hff), pimfs_pkg::RESP_OKAY);
      for (int s = 0; s < 8; s++) uframe(5'h05, 3'(s), 1'b1);
      axi_rd(pimfs_pkg::OFS_WORD_FIVE, five_exp(8'hff, 8'h00), pimfs_pkg::RESP_OKAY);
      for (int s = 0; s < 8; s++) axi_rd(pimfs_pkg::OFS_COUNT_BASE + 6'(4 * s),
         (s & 2) ? 32'h0 : 32'h100 + s, pimfs_pkg::RESP_OKAY);
      final_report();
   end
endmodule
`default_nettype wire
